// ==== rtl/chilc_consts.svh ====
`ifndef CHILC_CONSTS_SVH
`define CHILC_CONSTS_SVH

// register port geometry
`define CHILC_ADDR_W 12
`define CHILC_DATA_W 8

// register offsets
`define CHILC_OFF_INT_CFG 12'h11A
`define CHILC_OFF_LINK_SEL 12'h11B
`define CHILC_OFF_IRQ_STAT 12'h130
`define CHILC_OFF_IRQ_EN 12'h131

// interrupt_config field positions
`define CHILC_CFG_CLR_STYLE_BIT 2
`define CHILC_CFG_AUTOCLR_BIT 1
`define CHILC_CFG_MASTER_BIT 0

// link_controller_select field positions
`define CHILC_LINK_EN_LSB 2
`define CHILC_LINK_SEL_LSB 0

// reset values
`define CHILC_RST_CLR_STYLE 1'h0
`define CHILC_RST_AUTOCLR 1'h0
`define CHILC_RST_MASTER 1'h0
`define CHILC_RST_LINK_EN 3'h7
`define CHILC_RST_LINK_SEL 2'h0

// select field encodings
`define CHILC_SEL_CTRL2 2'h1
`define CHILC_SEL_CTRL3 2'h2

`endif

// ==== rtl/chilc_pkg.sv ====
`include "chilc_consts.svh"

package chilc_pkg;

    // one register port request, sampled every cycle
    typedef struct packed {
        logic [`CHILC_ADDR_W-1:0] addr;
        logic [`CHILC_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } chilc_bus_req_t;

    // what a link controller sends in place of its traffic
    typedef enum logic [1:0] {
        CHILC_FILL_NONE,
        CHILC_FILL_ONES,
        CHILC_FILL_FLAG
    } chilc_fill_t;

    // transmit state reported by one link controller
    typedef struct packed {
        logic busy;
        logic msg_frame;
    } chilc_link_stat_t;

endpackage

// ==== rtl/chilc_top.sv ====
`timescale 1ns/10ps
`include "chilc_consts.svh"

// Operation
// - style 0: reading status clears it
// - style 1: status survives reads, write clears
// - autoclear 0: enables survive status reads
// - autoclear 1: status read drops matching enables
// - master enable gates all interrupt generation
// - three controller enables, reset to one
// - disable during bit message sends ones
// - disable during frame sends idle flags
// - select 00/11 ctrl1, 01 ctrl2, 10 ctrl3
// - interrupt configuration bits reset to zero
module chilc_top #(
    parameter int N_EVT = 8
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire chilc_pkg::chilc_bus_req_t bus_req_in,
    output logic [`CHILC_DATA_W-1:0] bus_rdata_out,
    input wire logic [N_EVT-1:0] irq_event_in,
    input wire chilc_pkg::chilc_link_stat_t [2:0] link_stat_in,
    output logic irq_out,
    output logic [2:0] link_ctrl_enable_out,
    output chilc_pkg::chilc_fill_t [2:0] link_fill_out,
    output logic [2:0] link_abort_out,
    output logic [2:0] link_sel_onehot_out
);
    import chilc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic status_clear_style_select;
    logic enable_autoclear;
    logic channel_irq_master_enable;
    logic [1:0] link_sel;
    logic [N_EVT-1:0] irq_stat;
    logic [N_EVT-1:0] irq_en;
    logic [N_EVT-1:0] stat_clr;
    logic [`CHILC_DATA_W-1:0] next_rdata;

    // address decode
    logic wr_cfg;
    logic wr_link;
    logic wr_stat;
    logic wr_en;
    logic rd_stat;

    assign wr_cfg = bus_req_in.wr && (bus_req_in.addr == `CHILC_OFF_INT_CFG);
    assign wr_link = bus_req_in.wr && (bus_req_in.addr == `CHILC_OFF_LINK_SEL);
    assign wr_stat = bus_req_in.wr && (bus_req_in.addr == `CHILC_OFF_IRQ_STAT);
    assign wr_en = bus_req_in.wr && (bus_req_in.addr == `CHILC_OFF_IRQ_EN);
    assign rd_stat = bus_req_in.rd && (bus_req_in.addr == `CHILC_OFF_IRQ_STAT);

    ////////////////////////////////////////////////////////////////////////
    // interrupt configuration register

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            status_clear_style_select <= `CHILC_RST_CLR_STYLE;
            enable_autoclear <= `CHILC_RST_AUTOCLR;
            channel_irq_master_enable <= `CHILC_RST_MASTER;
        end else if (wr_cfg) begin
            status_clear_style_select <= bus_req_in.wdata[`CHILC_CFG_CLR_STYLE_BIT];
            enable_autoclear <= bus_req_in.wdata[`CHILC_CFG_AUTOCLR_BIT];
            channel_irq_master_enable <= bus_req_in.wdata[`CHILC_CFG_MASTER_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link controller enables and select

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            link_ctrl_enable_out <= `CHILC_RST_LINK_EN;
            link_sel <= `CHILC_RST_LINK_SEL;
        end else if (wr_link) begin
            link_ctrl_enable_out <= bus_req_in.wdata[`CHILC_LINK_EN_LSB +: 3];
            link_sel <= bus_req_in.wdata[`CHILC_LINK_SEL_LSB +: 2];
        end
    end

    // select decode; 11 folds onto controller 1 rather than selecting nothing
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            link_sel_onehot_out <= 3'h1;
        end else begin
            case (link_sel)
                `CHILC_SEL_CTRL2: begin
                    link_sel_onehot_out <= 3'h2;
                end
                `CHILC_SEL_CTRL3: begin
                    link_sel_onehot_out <= 3'h4;
                end
                default: begin
                    link_sel_onehot_out <= 3'h1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fill pattern per controller after a disable during transmission

    for (genvar i = 0; i < 3; i++) begin : g_link
        logic falls;
        assign falls = wr_link && link_ctrl_enable_out[i]
                       && !bus_req_in.wdata[`CHILC_LINK_EN_LSB + i];

        // fill holds until software enables the controller again
        always_ff @(posedge core_clk_in) begin
            if (sys_rst_in) begin
                link_fill_out[i] <= CHILC_FILL_NONE;
                link_abort_out[i] <= 1'h0;
            end else begin
                link_abort_out[i] <= falls && link_stat_in[i].busy;
                if (falls && link_stat_in[i].busy) begin
                    if (link_stat_in[i].msg_frame) begin
                        link_fill_out[i] <= CHILC_FILL_FLAG;
                    end else begin
                        link_fill_out[i] <= CHILC_FILL_ONES;
                    end
                end else if (wr_link && bus_req_in.wdata[`CHILC_LINK_EN_LSB + i]) begin
                    link_fill_out[i] <= CHILC_FILL_NONE;
                end
            end
        end

        sequence s_disable_busy;
            falls && link_stat_in[i].busy;
        endsequence

        property p_ones_fill;
            @(posedge core_clk_in) disable iff (sys_rst_in)
            (s_disable_busy and !link_stat_in[i].msg_frame)
                |=> (link_fill_out[i] == CHILC_FILL_ONES) && link_abort_out[i];
        endproperty
        a_ones_fill: assert property (p_ones_fill)
            else $error("bit message abort did not select ones fill");

        property p_flag_fill;
            @(posedge core_clk_in) disable iff (sys_rst_in)
            (s_disable_busy and link_stat_in[i].msg_frame)
                |=> (link_fill_out[i] == CHILC_FILL_FLAG) && link_abort_out[i];
        endproperty
        a_flag_fill: assert property (p_flag_fill)
            else $error("frame abort did not select idle flag fill");

        // the enable has dropped, so a second write cannot retrigger at once
        property p_abort_pulse;
            @(posedge core_clk_in) disable iff (sys_rst_in)
            link_abort_out[i] |=> !link_abort_out[i];
        endproperty
        a_abort_pulse: assert property (p_abort_pulse)
            else $error("abort pulse longer than one cycle");

        property p_idle_disable;
            @(posedge core_clk_in) disable iff (sys_rst_in)
            falls && !link_stat_in[i].busy |=> $stable(link_fill_out[i]) && !link_abort_out[i];
        endproperty
        a_idle_disable: assert property (p_idle_disable)
            else $error("idle controller disable changed its fill");

        property p_fill_release;
            @(posedge core_clk_in) disable iff (sys_rst_in)
            wr_link && bus_req_in.wdata[`CHILC_LINK_EN_LSB + i]
                |=> (link_fill_out[i] == CHILC_FILL_NONE) && link_ctrl_enable_out[i];
        endproperty
        a_fill_release: assert property (p_fill_release)
            else $error("re-enable did not release the fill");
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, enables and request

    // a read in clear-on-read mode wipes all bits; write-one clears otherwise
    always_comb begin
        stat_clr = '0;
        if (rd_stat && !status_clear_style_select) begin
            stat_clr = '1;
        end else if (wr_stat && status_clear_style_select) begin
            stat_clr = bus_req_in.wdata[N_EVT-1:0];
        end
    end

    // new events win over a clear in the same cycle
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~stat_clr) | irq_event_in;
        end
    end

    // autoclear drops the enables of the bits that the read reported
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            irq_en <= '0;
        end else if (wr_en) begin
            irq_en <= bus_req_in.wdata[N_EVT-1:0];
        end else if (rd_stat && enable_autoclear) begin
            irq_en <= irq_en & ~irq_stat;
        end
    end

    // one cycle later than the status, traded for a flop-driven output
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            irq_out <= 1'h0;
        end else begin
            irq_out <= channel_irq_master_enable && (|(irq_stat & irq_en));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, valid only in the cycle after the strobe

    always_comb begin
        next_rdata = '0;
        case (bus_req_in.addr)
            `CHILC_OFF_INT_CFG: begin
                next_rdata[`CHILC_CFG_CLR_STYLE_BIT] = status_clear_style_select;
                next_rdata[`CHILC_CFG_AUTOCLR_BIT] = enable_autoclear;
                next_rdata[`CHILC_CFG_MASTER_BIT] = channel_irq_master_enable;
            end
            `CHILC_OFF_LINK_SEL: begin
                next_rdata[`CHILC_LINK_EN_LSB +: 3] = link_ctrl_enable_out;
                next_rdata[`CHILC_LINK_SEL_LSB +: 2] = link_sel;
            end
            `CHILC_OFF_IRQ_STAT: begin
                next_rdata[N_EVT-1:0] = irq_stat;
            end
            `CHILC_OFF_IRQ_EN: begin
                next_rdata[N_EVT-1:0] = irq_en;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            bus_rdata_out <= '0;
        end else if (bus_req_in.rd) begin
            bus_rdata_out <= next_rdata;
        end else begin
            bus_rdata_out <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_quiet_read(logic style);
        rd_stat && (status_clear_style_select == style) && !(|irq_event_in);
    endsequence

    property p_rur_clear;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        s_quiet_read(1'h0) |=> (irq_stat == '0);
    endproperty
    a_rur_clear: assert property (p_rur_clear)
        else $error("status not cleared by read");

    property p_wc_keep;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        s_quiet_read(1'h1) |=> (irq_stat == $past(irq_stat));
    endproperty
    a_wc_keep: assert property (p_wc_keep)
        else $error("status changed by read in write-clear mode");

    property p_en_keep;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        rd_stat && !enable_autoclear |=> (irq_en == $past(irq_en));
    endproperty
    a_en_keep: assert property (p_en_keep)
        else $error("enables changed by status read");

    property p_en_autoclr;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        rd_stat && enable_autoclear
            |=> ((irq_en & $past(irq_stat)) == '0) && ((irq_en & ~$past(irq_stat))
                == ($past(irq_en) & ~$past(irq_stat)));
    endproperty
    a_en_autoclr: assert property (p_en_autoclr)
        else $error("autoclear did not drop exactly the read enables");

    property p_master_gate;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        !channel_irq_master_enable [*2] |-> !irq_out;
    endproperty
    a_master_gate: assert property (p_master_gate)
        else $error("interrupt raised with master enable off");

    property p_reset_vals;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        $fell(sys_rst_in) |-> (link_ctrl_enable_out == 3'h7) && !status_clear_style_select
            && !enable_autoclear && !channel_irq_master_enable && !irq_out;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("wrong value after reset");

    property p_sel_decode;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        !$fell(sys_rst_in) |-> (link_sel_onehot_out ==
            (($past(link_sel) == 2'h1) ? 3'h2 : ($past(link_sel) == 2'h2) ? 3'h4 : 3'h1));
    endproperty
    a_sel_decode: assert property (p_sel_decode)
        else $error("controller select decode wrong");

    property p_wc_write;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        wr_stat && status_clear_style_select && !(|irq_event_in)
            |=> (irq_stat == ($past(irq_stat) & ~$past(bus_req_in.wdata[N_EVT-1:0])));
    endproperty
    a_wc_write: assert property (p_wc_write)
        else $error("write-one clear wrong");

    property p_irq_req;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        channel_irq_master_enable && (|(irq_stat & irq_en)) |=> irq_out;
    endproperty
    a_irq_req: assert property (p_irq_req)
        else $error("interrupt request missing");

    property p_set_wins;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (|irq_event_in) |=> ((irq_stat & $past(irq_event_in)) == $past(irq_event_in));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost against clear");

    // master and clear style land in their documented bit positions
    property p_cfg_write;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        wr_cfg |=> (channel_irq_master_enable == $past(bus_req_in.wdata[`CHILC_CFG_MASTER_BIT]))
            && (status_clear_style_select == $past(bus_req_in.wdata[`CHILC_CFG_CLR_STYLE_BIT]));
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("configuration write not taken");

endmodule

// ==== test/tb.sv ====
`timescale 1ns/10ps
`include "chilc_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// one compare, counted; x never matches
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin miscompares++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, act, exp); end end

module tb;
    import chilc_pkg::*;

    logic core_clk_in = 1'h0;
    logic sys_rst_in = 1'h1;
    chilc_bus_req_t bus = '0;
    logic [7:0] rdata;
    logic [7:0] ev = 8'h00;
    chilc_link_stat_t [2:0] lstat = '0;
    logic irq;
    logic [2:0] lena;
    chilc_fill_t [2:0] fill;
    logic [2:0] abort;
    logic [2:0] onehot;
    int miscompares = 0;
    int checked = 0;

    // 200 MHz
    always #2.5 core_clk_in = ~core_clk_in;

    chilc_top #(.N_EVT(8)) i_chilc_top (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .bus_req_in(bus),
        .bus_rdata_out(rdata),
        .irq_event_in(ev),
        .link_stat_in(lstat),
        .irq_out(irq),
        .link_ctrl_enable_out(lena),
        .link_fill_out(fill),
        .link_abort_out(abort),
        .link_sel_onehot_out(onehot)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // one-cycle write; returns just after the taking edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge core_clk_in);
        bus.wr <= 1'h0;
        #1;
    endtask

    // one-cycle read; data looked at only in the following cycle
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge core_clk_in);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        @(posedge core_clk_in);
        bus.rd <= 1'h0;
        #1;
        `CHK(rdata, exp)
    endtask

    // single-cycle event pulse on the given bits
    task automatic pulse(input logic [7:0] bits);
        @(posedge core_clk_in);
        ev <= bits;
        @(posedge core_clk_in);
        ev <= 8'h00;
    endtask

    // bounded wait for the interrupt level
    task automatic wait_irq(input logic exp);
        int n;
        for (n = 0; n < 6 && irq !== exp; n++) begin
            @(posedge core_clk_in);
            #1;
        end
        `CHK(irq, exp)
        if (irq !== exp) begin
            end_of_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK(lena, 3'h7)
        `CHK(onehot, 3'h1)
        `CHK(irq, 1'h0)
        rd(`CHILC_OFF_INT_CFG, 8'h00);
        rd(`CHILC_OFF_LINK_SEL, 8'h1C);
        rd(12'h3FF, 8'h00); // unmapped reads back zero
    endtask

    // every select code, 11 folds onto controller one
    task automatic t_select();
        logic [2:0] exp;
        for (int s = 0; s < 4; s++) begin
            wr(`CHILC_OFF_LINK_SEL, 8'h1C | 8'(s));
            @(posedge core_clk_in);
            #1;
            exp = (s == 1) ? 3'h2 : (s == 2) ? 3'h4 : 3'h1;
            `CHK(onehot, exp)
        end
    endtask

    // clear-on-read plus master gating
    task automatic t_clear_on_read();
        wr(`CHILC_OFF_IRQ_EN, 8'h01);
        pulse(8'h01);
        repeat (3) @(posedge core_clk_in);
        #1;
        `CHK(irq, 1'h0)
        wr(`CHILC_OFF_INT_CFG, 8'h01);
        wait_irq(1'h1);
        rd(`CHILC_OFF_IRQ_STAT, 8'h01);
        rd(`CHILC_OFF_IRQ_STAT, 8'h00);
        wait_irq(1'h0);
        rd(`CHILC_OFF_IRQ_EN, 8'h01);
    endtask

    // write-one clear: reads leave status alone
    task automatic t_write_clear();
        wr(`CHILC_OFF_INT_CFG, 8'h05);
        pulse(8'h03);
        rd(`CHILC_OFF_IRQ_STAT, 8'h03);
        rd(`CHILC_OFF_IRQ_STAT, 8'h03);
        wr(`CHILC_OFF_IRQ_STAT, 8'h01);
        rd(`CHILC_OFF_IRQ_STAT, 8'h02);
        wait_irq(1'h0);
        wr(`CHILC_OFF_IRQ_EN, 8'h02);
        wait_irq(1'h1);
        wr(`CHILC_OFF_IRQ_STAT, 8'h02);
        rd(`CHILC_OFF_IRQ_STAT, 8'h00);
    endtask

    // auto-clear drops only enables of bits seen set
    task automatic t_autoclear();
        wr(`CHILC_OFF_INT_CFG, 8'h03);
        wr(`CHILC_OFF_IRQ_EN, 8'h05);
        pulse(8'h01);
        rd(`CHILC_OFF_IRQ_STAT, 8'h01);
        rd(`CHILC_OFF_IRQ_EN, 8'h04);
        wr(`CHILC_OFF_INT_CFG, 8'h00);
        wait_irq(1'h0);
    endtask

    // disable in mid-transfer: bit message vs frame, idle one untouched
    task automatic t_link_abort();
        @(posedge core_clk_in);
        lstat <= 6'h0E;
        wr(`CHILC_OFF_LINK_SEL, 8'h10);
        `CHK(lena, 3'h4)
        `CHK(fill[0], CHILC_FILL_ONES)
        `CHK(fill[1], CHILC_FILL_FLAG)
        `CHK(fill[2], CHILC_FILL_NONE)
        `CHK(abort, 3'h3)
        @(posedge core_clk_in);
        #1;
        `CHK(abort, 3'h0)
        `CHK(fill[1], CHILC_FILL_FLAG)
        wr(`CHILC_OFF_LINK_SEL, 8'h00);
        `CHK(fill[2], CHILC_FILL_NONE)
        `CHK(lena, 3'h0)
        wr(`CHILC_OFF_LINK_SEL, 8'h1C);
        `CHK(fill[0], CHILC_FILL_NONE)
        `CHK(lena, 3'h7)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence; a second reset checks the defaults again
    initial begin
        repeat (12) @(posedge core_clk_in);
        sys_rst_in <= 1'h0;
        @(posedge core_clk_in);
        #1;
        t_reset();
        t_select();
        t_clear_on_read();
        t_write_clear();
        t_autoclear();
        t_link_abort();
        wr(`CHILC_OFF_INT_CFG, 8'h07);
        @(posedge core_clk_in);
        sys_rst_in <= 1'h1;
        repeat (12) @(posedge core_clk_in);
        sys_rst_in <= 1'h0;
        @(posedge core_clk_in);
        #1;
        t_reset();
        end_of_test();
    end
endmodule
